// ===== src/sacs_top.sv
// control sequencer of the serial 8-bit converter
`timescale 1ns/1ps
module sacs_top (
  // conversion clock and reset
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  // serial link
  input  wire logic       io_clk_i,
  input  wire logic       cs_n_i,
  input  wire logic       addr_i,
  output logic            data_o,
  output logic            data_oe_o,
  // analog core side
  input  wire logic [7:0] adc_code_i,
  output logic [3:0]      chan_o,
  output logic            sample_o,
  output logic            hold_o
);
  // ---------------- conversion clock domain ----------------
  logic       cs_meta_ff;
  logic       cs_sync_ff;
  logic [1:0] qual_cnt_ff;
  logic       sel_ok_ff;
  logic       sel_d_ff;
  logic       tgl_meta_ff;
  logic       tgl_s1_ff;
  logic       tgl_s2_ff;
  logic       act_meta_ff;
  logic       act_sync_ff;
  logic       busy_ff;
  logic [5:0] conv_cnt_ff;
  logic [3:0] chan_ff;
  logic [7:0] result_ff;
  logic       start;
  logic       abort;
  logic       done;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] conv_value;

  // ---------------- link clock domain ----------------
  logic       io_rst_n;
  logic       en_meta_ff;
  logic       en_ff;
  logic [2:0] rcnt_ff;
  logic [2:0] fcnt_ff;
  logic [3:0] addr_sh_ff;
  logic [3:0] addr_lat_ff;
  logic       start_tgl_ff;
  logic       fseen_ff;
  logic       dout_ff;
  logic       sample_ff;
  logic       active_ff;

  // select pin into conversion domain
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
    end else begin
      cs_meta_ff <= cs_n_i;
      cs_sync_ff <= cs_meta_ff;
    end
  end

  // count rising edges while select low
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qual_cnt_ff <= '0;
    end else if (cs_sync_ff) begin
      qual_cnt_ff <= '0;
    end else if (qual_cnt_ff != sacs_pkg::QUAL_RISES) begin
      qual_cnt_ff <= qual_cnt_ff + 2'h1; // (R02)
    end
  end

  // recognition on the following falling edge
  always_ff @(negedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_ok_ff <= 1'b0;
    end else begin
      sel_ok_ff <= ~cs_sync_ff & (qual_cnt_ff == sacs_pkg::QUAL_RISES); // (R02)
    end
  end

  // start toggle and activity level from link domain
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_d_ff    <= 1'b0;
      tgl_meta_ff <= 1'b0;
      tgl_s1_ff   <= 1'b0;
      tgl_s2_ff   <= 1'b0;
      act_meta_ff <= 1'b0;
      act_sync_ff <= 1'b0;
    end else begin
      sel_d_ff    <= sel_ok_ff;
      tgl_meta_ff <= start_tgl_ff;
      tgl_s1_ff   <= tgl_meta_ff;
      tgl_s2_ff   <= tgl_s1_ff;
      act_meta_ff <= active_ff;
      act_sync_ff <= act_meta_ff;
    end
  end

  assign start = tgl_s1_ff ^ tgl_s2_ff;                       // (R13)
  assign abort = sel_ok_ff & ~sel_d_ff;                       // (R11)
  assign done  = busy_ff & (conv_cnt_ff == sacs_pkg::CONV_LAST) & fifo_in_ready;
  assign conv_value = (chan_ff == sacs_pkg::SELFTEST_ADDR) ?
                      sacs_pkg::SELFTEST_CODE : adc_code_i;   // (R18)

  // conversion sequencer
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_ff     <= 1'b0;
      conv_cnt_ff <= '0;
      chan_ff     <= '0;
    end else if (start) begin
      busy_ff     <= 1'b1; // (R08) (R12) (R16)
      conv_cnt_ff <= '0;
      chan_ff     <= addr_lat_ff;
    end else if (abort) begin
      busy_ff     <= 1'b0; // (R11)
      conv_cnt_ff <= '0;
    end else if (done) begin
      busy_ff     <= 1'b0;
    end else if (busy_ff && conv_cnt_ff != sacs_pkg::CONV_LAST) begin
      conv_cnt_ff <= conv_cnt_ff + 6'h01; // (R08)
    end
  end

  sacs_fifo #(
    .WIDTH (sacs_pkg::RES_BITS),
    .DEPTH (sacs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (done),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (conv_value),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // result may change only outside a shift sequence
  assign fifo_out_ready = ~(sel_ok_ff & act_sync_ff);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_ff <= sacs_pkg::RESULT_RESET;
    end else if (fifo_out_valid && fifo_out_ready) begin
      result_ff <= fifo_out_data; // (R19)
    end
  end

  // link logic held in reset while select not recognized
  assign io_rst_n = nrst_i & sel_ok_ff; // (R01) (R11)

  // first two link clocks only enable shifting
  always_ff @(posedge io_clk_i or negedge io_rst_n) begin
    if (!io_rst_n) begin
      en_meta_ff <= 1'b0;
      en_ff      <= 1'b0;
    end else begin
      en_meta_ff <= 1'b1;
      en_ff      <= en_meta_ff; // (R14)
    end
  end

  // address capture on rising edges
  always_ff @(posedge io_clk_i or negedge io_rst_n) begin
    if (!io_rst_n) begin
      rcnt_ff    <= '0;
      addr_sh_ff <= '0;
    end else if (en_ff) begin
      rcnt_ff <= rcnt_ff + 3'h1; // (R10)
      if (rcnt_ff < sacs_pkg::ADDR_RISES) begin
        addr_sh_ff <= {addr_sh_ff[2:0], addr_i}; // (R04)
      end
    end
  end

  // result shift, sample window and start on falling edges
  always_ff @(negedge io_clk_i or negedge io_rst_n) begin
    if (!io_rst_n) begin
      fcnt_ff      <= '0;
      fseen_ff     <= 1'b0;
      dout_ff      <= 1'b0;
      sample_ff    <= 1'b0;
    end else if (active_ff) begin
      fcnt_ff  <= fcnt_ff + 3'h1;
      fseen_ff <= 1'b1;
      dout_ff  <= result_ff[3'(sacs_pkg::FIRST_SHIFT - fcnt_ff)]; // (R05) (R07)
      if (fcnt_ff == sacs_pkg::SAMPLE_FALL) begin
        sample_ff <= 1'b1; // (R06)
      end else if (fcnt_ff == sacs_pkg::LAST_FALL) begin
        sample_ff <= 1'b0; // (R08) (R17)
      end
    end
  end

  // start toggle and channel survive deselection
  always_ff @(negedge io_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_tgl_ff <= 1'b0;
      addr_lat_ff  <= '0;
    end else if (active_ff && sel_ok_ff && fcnt_ff == sacs_pkg::LAST_FALL) begin
      start_tgl_ff <= ~start_tgl_ff; // (R08) (R12)
      addr_lat_ff  <= addr_sh_ff;
    end
  end

  // sequence in progress
  always_ff @(posedge io_clk_i or negedge io_rst_n) begin
    if (!io_rst_n) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= en_ff;
    end
  end

  assign data_oe_o = sel_ok_ff;                                  // (R01)
  assign data_o    = sel_ok_ff & (fseen_ff ? dout_ff : result_ff[7]); // (R03)
  assign sample_o  = sample_ff;
  assign hold_o    = busy_ff;
  assign chan_o    = chan_ff;
endmodule : sacs_top

// ===== src/sacs_pkg.sv
// constants of the serial converter control sequencer
// Operation
// (R01) select high: output released, address and shift clock ignored
// (R02) select low counts after two rising, then one falling conversion-clock edge
// (R03) recognized select puts previous result msb on output with no clock edge
// (R04) 4-bit address, msb first, taken on first four shift-clock rising edges
// (R05) first four shift falling edges output result bits two to five
// (R06) sampling of new channel begins after fourth shift falling edge; the code keeps chan_o at the previous channel until conversion start
// (R07) next three falling edges output result bits six to eight
// (R08) eighth falling edge ends sampling, holds, starts 36-cycle conversion
// (R09) controller raises select or keeps shift clock low 36 cycles after
// (R10) select may stay low over conversions; shift clock must be glitch free
// (R11) early recognized select fall resets device and aborts conversion
// (R12) full new sequence mid-conversion aborts it; previous result delivered
// (R13) shift clock and conversion clock fully independent
// (R14) shared clock: first two clocks after select fall shift nothing
// (R15) shared clock: controller raises select after ten clocks total
// (R16) shared clock: common clock is conversion clock once select high
// (R17) strobed start: sampling lasts until eighth falling edge, then hold
// (R18) address 1011 converts internal self-test level, code 7D to 83
// (R19) finished conversion loads result for next access; abort leaves it
package sacs_pkg;
  localparam int unsigned RES_BITS      = 8;
  localparam int unsigned ADDR_BITS     = 4;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam logic [5:0]  CONV_LAST     = 6'h23;
  localparam logic [1:0]  QUAL_RISES    = 2'h2;
  localparam logic [2:0]  SAMPLE_FALL   = 3'h3;
  localparam logic [2:0]  LAST_FALL     = 3'h7;
  localparam logic [2:0]  ADDR_RISES    = 3'h4;
  localparam logic [2:0]  FIRST_SHIFT   = 3'h6;
  localparam logic [3:0]  SELFTEST_ADDR = 4'hB;
  localparam logic [7:0]  SELFTEST_CODE = 8'h80;
  localparam logic [7:0]  RESULT_RESET  = 8'h00;
endpackage : sacs_pkg

// ===== src/sacs_fifo.sv
// result buffer with registered read data
`timescale 1ns/1ps
module sacs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wptr_ff;
  logic [PW-1:0]    rptr_ff;
  logic [PW:0]      cnt_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_ff != (PW+1)'(DEPTH));
  assign push        = in_valid_i & in_ready_o;
  assign pop         = (cnt_ff != '0) & (~out_valid_ff | out_ready_i);
  assign out_valid_o = out_valid_ff;
  assign out_data_o  = out_data_ff;

  // storage
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_ff[wptr_ff] <= in_data_i;
    end
  end

  // pointers and level
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff  <= '0;
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == PW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == PW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // output register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem_ff[rptr_ff];
    end else if (out_ready_i) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule : sacs_fifo

// ===== testbench/sacs_properties.sv
// port checks of the converter control sequencer
`timescale 1ns/1ps
module sacs_properties (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       nrst_i,
  // link and core side
  input wire logic       cs_n_i,
  input wire logic       data_o,
  input wire logic       data_oe_o,
  input wire logic [3:0] chan_o,
  input wire logic       sample_o,
  input wire logic       hold_o
);
  logic [6:0] busy_ff;
  // length of the current conversion
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) busy_ff <= 7'h00;
    else busy_ff <= hold_o ? busy_ff + 7'h01 : 7'h00;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence cs_drop;
    $fell(cs_n_i) ##1 !cs_n_i[*4];
  endsequence
  sequence end_of_sample;
    $fell(sample_o);
  endsequence
  a_idle_released: assert property (cs_n_i[*4] |-> !data_oe_o)
    else $error("pin driven while idle");
  a_quiet_output: assert property (!data_oe_o |-> !data_o)
    else $error("data while released");
  a_select_delay: assert property ($fell(cs_n_i) |-> !data_oe_o[*3])
    else $error("select taken too early");
  a_select_seen: assert property (cs_drop |-> data_oe_o)
    else $error("select not taken");
  a_hold_length: assert property ($fell(hold_o) && !data_oe_o |-> busy_ff >= 7'h24)
    else $error("conversion too short");
  a_hold_start: assert property (end_of_sample |-> ##[0:6] hold_o)
    else $error("no hold after sampling");
  a_hold_no_sample: assert property ($rose(hold_o) |-> !sample_o)
    else $error("hold while sampling");
  a_chan_update: assert property ($changed(chan_o) |-> ##[0:1] hold_o)
    else $error("channel moved outside start");
endmodule : sacs_properties
bind sacs_top sacs_properties i_props (.clock_i(clock_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i),
  .data_o(data_o), .data_oe_o(data_oe_o), .chan_o(chan_o), .sample_o(sample_o),
  .hold_o(hold_o));

// ===== testbench/sacs_ctrl_model.sv
// controller model driving select, shift clock and address
`timescale 1ns/1ps
module sacs_ctrl_model (
  // conversion clock
  input  wire logic clock_i,
  // serial link
  input  wire logic data_i,
  input  wire logic data_oe_i,
  output logic      io_clk_o,
  output logic      cs_n_o,
  output logic      addr_o
);
  initial begin
    io_clk_o = 1'b0;
    cs_n_o = 1'b1;
    addr_o = 1'b0;
  end
  // one access: ten shift cycles, first two spent on qualification
  task automatic frame(input logic [3:0] a, input int stretch, output logic [7:0] rx,
                       output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    rx = 8'h00;
    while (data_oe_i !== 1'b0 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    n = 0;
    repeat (2) @(posedge clock_i);
    @(posedge clock_i) cs_n_o <= 1'b0;
    while (data_oe_i !== 1'b1 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    if (data_oe_i === 1'b1) begin
      ok = 1'b1;
      #3;
      for (int i = 0; i < 10; i++) begin
        addr_o = (i >= 2 && i < 6) ? a[5-i] : ~addr_o;
        #6 io_clk_o = 1'b1;
        if (i >= 2) rx[9-i] = data_i;
        if (i == 9) #(stretch);
        #6 io_clk_o = 1'b0;
      end
    end
    @(posedge clock_i) cs_n_o <= 1'b1;
    addr_o = ~addr_o;
  endtask : frame
endmodule : sacs_ctrl_model

// ===== testbench/tb_serial_adc_control_sequencer.sv
// self-checking bench of the converter control sequencer
`timescale 1ns/1ps
module tb_serial_adc_control_sequencer;
  logic       clock_i;
  logic       nrst_i;
  logic       io_clk;
  logic       cs_n;
  logic       addr;
  logic       data;
  logic       data_oe;
  logic [7:0] adc_code;
  logic [3:0] chan;
  logic       sample;
  logic       hold;
  int         failures;
  int         cmp_count;
  int         n;
  sacs_top i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .io_clk_i(io_clk), .cs_n_i(cs_n),
    .addr_i(addr), .data_o(data), .data_oe_o(data_oe), .adc_code_i(adc_code),
    .chan_o(chan), .sample_o(sample), .hold_o(hold));
  sacs_ctrl_model i_ctl (.clock_i(clock_i), .data_i(data), .data_oe_i(data_oe),
    .io_clk_o(io_clk), .cs_n_o(cs_n), .addr_o(addr));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_hold(input logic lvl, output int k);
    k = 0;
    while (hold !== lvl) begin
      @(negedge clock_i);
      k++;
      if (k > 300) begin
        failures++;
        end_of_test();
      end
    end
  endtask : wait_hold
  task automatic access(input logic [3:0] a, input logic [7:0] code, input logic [7:0] exp,
                        input int stretch);
    logic [7:0] rx;
    logic       ok;
    @(posedge clock_i) adc_code <= code;
    i_ctl.frame(a, stretch, rx, ok);
    chk({7'h00, ok}, 8'h01);
    if (ok !== 1'b1) end_of_test();
    chk(rx, exp);
  endtask : access
  task automatic s_reset;
    @(negedge clock_i);
    chk({data_oe, data, sample, hold, chan}, 8'h00);
  endtask : s_reset
  task automatic s_basic;
    access(4'h5, 8'hA5, 8'h00, 0);
    wait_hold(1'b1, n);
    wait_hold(1'b0, n);
    chk({4'h0, chan}, 8'h05);
    chk({data_oe, data, sample, 5'h00}, 8'h00);
  endtask : s_basic
  task automatic s_selftest;
    access(4'hB, 8'h5A, 8'hA5, 0);
    wait_hold(1'b1, n);
    wait_hold(1'b0, n);
    access(4'h2, 8'hC3, 8'h80, 0);
    wait_hold(1'b1, n);
    wait_hold(1'b0, n);
  endtask : s_selftest
  task automatic s_strobe;
    access(4'h9, 8'h3C, 8'hC3, 200);
    wait_hold(1'b1, n);
    wait_hold(1'b0, n);
    chk({4'h0, chan}, 8'h09);
  endtask : s_strobe
  task automatic s_abort;
    access(4'h3, 8'h11, 8'h3C, 0);
    access(4'h6, 8'h77, 8'h3C, 0);
    wait_hold(1'b1, n);
    wait_hold(1'b0, n);
    chk({7'h00, n > 31}, 8'h01);
    chk({4'h0, chan}, 8'h06);
    access(4'h0, 8'h00, 8'h77, 0);
    wait_hold(1'b1, n);
    wait_hold(1'b0, n);
  endtask : s_abort
  initial begin
    failures = 0;
    cmp_count = 0;
    nrst_i = 1'b0;
    adc_code = 8'h00;
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'b1;
    s_reset();
    s_basic();
    s_selftest();
    s_strobe();
    s_abort();
    end_of_test();
  end
endmodule : tb_serial_adc_control_sequencer
